// File: src/hwb_pkg.sv
// ****************************************************************
// Register map and field layout
// ****************************************************************
package hwb_pkg;

    // Register indices on the index/data port
    localparam logic [7:0] HWB_IDX_FAN_PIN_CTRL = 8'h4D;
    localparam logic [7:0] HWB_IDX_BANK_SELECT  = 8'h4E;
    localparam logic [7:0] HWB_IDX_VENDOR_ID    = 8'h4F;
    localparam logic [7:0] HWB_IDX_BEEP_ONE     = 8'h56;
    localparam logic [7:0] HWB_IDX_BEEP_TWO     = 8'h57;

    // Bank that holds the beep registers in the upper index range
    localparam logic [2:0] HWB_BANK_ZERO        = 3'h0;
    localparam logic [7:0] HWB_UPPER_LO         = 8'h50;
    localparam logic [7:0] HWB_UPPER_HI         = 8'h5F;

    // Fan pin control fields
    localparam int HWB_SYS_TACH_BIT  = 0;
    localparam int HWB_SYS_LEVEL_BIT = 1;
    localparam int HWB_CPU_TACH_BIT  = 2;
    localparam int HWB_CPU_LEVEL_BIT = 3;

    // Bank select fields
    localparam int HWB_HIGH_BYTE_BIT = 7;
    localparam int HWB_BANK_MSB      = 2;

    // Second beep register field
    localparam int HWB_MASTER_BIT    = 7;

    // Reset values
    localparam logic [7:0] HWB_FAN_RST  = 8'h05;
    localparam logic [7:0] HWB_BANK_RST = 8'h80;
    localparam logic [7:0] HWB_BEEP_RST = 8'h00;
    localparam logic       HWB_MASTER_RST = 1'b1;

    // Vendor identifier, value arbitrary
    localparam logic [15:0] HWB_VENDOR_ID_DEF = 16'h1234;

    // Value returned for unmapped indices
    localparam logic [7:0] HWB_RD_NONE = 8'h00;

endpackage : hwb_pkg

// File: src/hwb_fan_pin.sv
`timescale 1ns/1ps
// ****************************************************************
// One fan pin: tachometer input or driven level
// ****************************************************************
module hwb_fan_pin
    import hwb_pkg::*;
(
    input  wire logic i_clk_sys,
    input  wire logic i_rst_b,
    input  wire logic i_is_tach,
    input  wire logic i_out_level,
    input  wire logic i_pin,
    output logic      o_pin,
    output logic      o_pin_oe,
    output logic      o_tach
);

    // Pin drive and tachometer sample
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_pin    <= 1'b0;
            o_pin_oe <= 1'b0;
            o_tach   <= 1'b0;
        end else begin
            o_pin_oe <= ~i_is_tach;                 // Drive only in output mode
            o_pin    <= i_out_level & ~i_is_tach;   // Level ignored in tach mode
            o_tach   <= i_pin & i_is_tach;          // Tach pulses pass in input mode
        end
    end

endmodule : hwb_fan_pin

// File: src/hwb_regs.sv
`timescale 1ns/1ps
// Notes on behaviour
// - CPU fan direction bit 2 set (reset) makes the pin a tachometer input.
// - CPU fan direction bit clear drives the pin at the level in bit 3.
// - CPU fan level bit reaches the pin only in output mode.
// - System fan direction bit 0 set (reset) makes the pin a tachometer input.
// - System fan direction bit clear drives the pin at the level in bit 1.
// - Both fan level bits reset to zero, so output mode starts low.
// - Bank select bit 7 picks identifier high byte (one, reset) or low byte.
// - Bank select bits 2..0 pick the bank answering at indices 50h to 5Fh.
// - Read-only 16-bit identifier; upper byte returned while selector is one.
// - Lower identifier byte returned while selector is zero; writes ignored.
// - Beep enable bits 7..4: CPU fan, system fan, CPU temp, system temp.
// - Beep enable bits 3..0: five volt, analog supply, input zero, core.
// - Beep enable one allows, zero blocks; all eight reset to zero.
// - Master beep enable, set at reset, gates every beep.
module hwb_regs
    import hwb_pkg::*;
#(
    parameter logic [15:0] VENDOR_ID = HWB_VENDOR_ID_DEF  // Arbitrary value
) (
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst_b,
    input  wire logic [7:0] i_index,
    input  wire logic       i_wr_en,
    input  wire logic [7:0] i_wr_data,
    input  wire logic       i_rd_en,
    output logic      [7:0] o_rd_data,
    input  wire logic [7:0] i_out_of_limit,
    output logic            o_beep,
    output logic      [2:0] o_upper_bank,
    input  wire logic       i_cpu_fan_pin,
    output logic            o_cpu_fan_pin,
    output logic            o_cpu_fan_pin_oe,
    output logic            o_cpu_fan_tach,
    input  wire logic       i_sys_fan_pin,
    output logic            o_sys_fan_pin,
    output logic            o_sys_fan_pin_oe,
    output logic            o_sys_fan_tach
);

    // ************************************************************
    // Register state
    // ************************************************************
    logic       cpu_fan_pin_is_tach_q;
    logic       cpu_fan_pin_out_level_q;
    logic       sys_fan_pin_is_tach_q;
    logic       sys_fan_pin_out_level_q;
    logic       id_high_byte_select_q;
    logic [2:0] upper_index_bank_number_q;
    logic [7:0] beep_enable_one_q;
    logic       beep_master_enable_q;
    logic       bank_zero_hit;
    logic [7:0] rd_mux;
    logic [7:0] vendor_code_upper;
    logic [7:0] vendor_code_lower;

    assign vendor_code_upper = VENDOR_ID[15:8];
    assign vendor_code_lower = VENDOR_ID[7:0];

    // Upper index range answers only while bank zero is selected
    assign bank_zero_hit = (upper_index_bank_number_q == HWB_BANK_ZERO);

    // Fan pin control register
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cpu_fan_pin_is_tach_q   <= HWB_FAN_RST[HWB_CPU_TACH_BIT];
            cpu_fan_pin_out_level_q <= HWB_FAN_RST[HWB_CPU_LEVEL_BIT];
            sys_fan_pin_is_tach_q   <= HWB_FAN_RST[HWB_SYS_TACH_BIT];
            sys_fan_pin_out_level_q <= HWB_FAN_RST[HWB_SYS_LEVEL_BIT];
        end else if (i_wr_en && i_index == HWB_IDX_FAN_PIN_CTRL) begin
            cpu_fan_pin_is_tach_q   <= i_wr_data[HWB_CPU_TACH_BIT];
            cpu_fan_pin_out_level_q <= i_wr_data[HWB_CPU_LEVEL_BIT];
            sys_fan_pin_is_tach_q   <= i_wr_data[HWB_SYS_TACH_BIT];
            sys_fan_pin_out_level_q <= i_wr_data[HWB_SYS_LEVEL_BIT];
        end
    end

    // Bank select register; reserved bits are not stored
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            id_high_byte_select_q     <= HWB_BANK_RST[HWB_HIGH_BYTE_BIT];
            upper_index_bank_number_q <= HWB_BANK_RST[HWB_BANK_MSB:0];
        end else if (i_wr_en && i_index == HWB_IDX_BANK_SELECT) begin
            id_high_byte_select_q     <= i_wr_data[HWB_HIGH_BYTE_BIT];
            upper_index_bank_number_q <= i_wr_data[HWB_BANK_MSB:0];
        end
    end

    // Beep enable registers, bank zero only
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            beep_enable_one_q    <= HWB_BEEP_RST;
            beep_master_enable_q <= HWB_MASTER_RST;
        end else if (i_wr_en && bank_zero_hit) begin
            if (i_index == HWB_IDX_BEEP_ONE) begin
                beep_enable_one_q <= i_wr_data;
            end else if (i_index == HWB_IDX_BEEP_TWO) begin
                beep_master_enable_q <= i_wr_data[HWB_MASTER_BIT];
            end
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    // Read multiplexer; identifier writes have no target
    always_comb begin
        rd_mux = HWB_RD_NONE;
        if (i_index == HWB_IDX_FAN_PIN_CTRL) begin
            rd_mux[HWB_CPU_LEVEL_BIT] = cpu_fan_pin_out_level_q;
            rd_mux[HWB_CPU_TACH_BIT]  = cpu_fan_pin_is_tach_q;
            rd_mux[HWB_SYS_LEVEL_BIT] = sys_fan_pin_out_level_q;
            rd_mux[HWB_SYS_TACH_BIT]  = sys_fan_pin_is_tach_q;
        end else if (i_index == HWB_IDX_BANK_SELECT) begin
            rd_mux[HWB_HIGH_BYTE_BIT] = id_high_byte_select_q;  // Reserved read reset
            rd_mux[HWB_BANK_MSB:0]    = upper_index_bank_number_q;
        end else if (i_index == HWB_IDX_VENDOR_ID) begin
            if (id_high_byte_select_q) begin
                rd_mux = vendor_code_upper;
            end else begin
                rd_mux = vendor_code_lower;
            end
        end else if (i_index == HWB_IDX_BEEP_ONE && bank_zero_hit) begin
            rd_mux = beep_enable_one_q;
        end else if (i_index == HWB_IDX_BEEP_TWO && bank_zero_hit) begin
            rd_mux[HWB_MASTER_BIT] = beep_master_enable_q;
        end
    end

    // Registered read data, one cycle after the read strobe
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rd_data <= HWB_RD_NONE;
        end else if (i_rd_en) begin
            o_rd_data <= rd_mux;
        end
    end

    // ************************************************************
    // Beep and bank outputs
    // ************************************************************
    // Beep asserted for any enabled out-of-limit source under master
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_beep       <= 1'b0;
            o_upper_bank <= HWB_BANK_RST[HWB_BANK_MSB:0];
        end else begin
            o_beep       <= beep_master_enable_q &
                            (|(i_out_of_limit & beep_enable_one_q));
            o_upper_bank <= upper_index_bank_number_q;
        end
    end

    // ************************************************************
    // Fan pins
    // ************************************************************
    hwb_fan_pin u_cpu_fan_pin (
        .i_clk_sys   (i_clk_sys),
        .i_rst_b     (i_rst_b),
        .i_is_tach   (cpu_fan_pin_is_tach_q),
        .i_out_level (cpu_fan_pin_out_level_q),
        .i_pin       (i_cpu_fan_pin),
        .o_pin       (o_cpu_fan_pin),
        .o_pin_oe    (o_cpu_fan_pin_oe),
        .o_tach      (o_cpu_fan_tach)
    );

    hwb_fan_pin u_sys_fan_pin (
        .i_clk_sys   (i_clk_sys),
        .i_rst_b     (i_rst_b),
        .i_is_tach   (sys_fan_pin_is_tach_q),
        .i_out_level (sys_fan_pin_out_level_q),
        .i_pin       (i_sys_fan_pin),
        .o_pin       (o_sys_fan_pin),
        .o_pin_oe    (o_sys_fan_pin_oe),
        .o_tach      (o_sys_fan_tach)
    );

    // ************************************************************
    // Assertions
    // ************************************************************
    AST_CPU_TACH_NO_DRIVE: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        cpu_fan_pin_is_tach_q |=> !o_cpu_fan_pin_oe && !o_cpu_fan_pin)
        else $error("CPU fan pin driven in tachometer mode");

    AST_CPU_OUT_LEVEL: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        !cpu_fan_pin_is_tach_q |=>
            o_cpu_fan_pin_oe && (o_cpu_fan_pin == $past(cpu_fan_pin_out_level_q)))
        else $error("CPU fan pin level wrong in output mode");

    AST_CPU_LEVEL_MASKED: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (cpu_fan_pin_is_tach_q && cpu_fan_pin_out_level_q) |=> !o_cpu_fan_pin)
        else $error("CPU fan level leaked in tachometer mode");

    AST_SYS_TACH_PASS: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        sys_fan_pin_is_tach_q |=> !o_sys_fan_pin_oe && (o_sys_fan_tach == $past(i_sys_fan_pin)))
        else $error("System fan tachometer not passed");

    AST_SYS_OUT_LEVEL: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        !sys_fan_pin_is_tach_q |=>
            o_sys_fan_pin_oe && (o_sys_fan_pin == $past(sys_fan_pin_out_level_q)))
        else $error("System fan pin level wrong in output mode");

    AST_ID_BYTE_SELECT: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (i_rd_en && i_index == HWB_IDX_VENDOR_ID) |=>
            o_rd_data == ($past(id_high_byte_select_q) ? VENDOR_ID[15:8] : VENDOR_ID[7:0]))
        else $error("Identifier byte does not follow selector");

    AST_BANK_GATES_BEEP: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (i_wr_en && i_index == HWB_IDX_BEEP_ONE && !bank_zero_hit) |=> $stable(beep_enable_one_q))
        else $error("Beep register written outside its bank");

    AST_BEEP_CAUSE: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        o_beep |-> $past(beep_master_enable_q) && ($past(i_out_of_limit & beep_enable_one_q) != 8'h00))
        else $error("Beep without enabled cause");

    AST_MASTER_MUTES: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        !beep_master_enable_q |=> !o_beep)
        else $error("Beep while master enable is clear");

    AST_BEEP_SOUNDS: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (beep_master_enable_q && |(i_out_of_limit & beep_enable_one_q)) |=> o_beep)
        else $error("Enabled source failed to beep");

    AST_BANK_RESERVED_ZERO: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (i_rd_en && i_index == HWB_IDX_BANK_SELECT) |=> o_rd_data[6:3] == 4'h0)
        else $error("Reserved bank select bits not at reset value");

endmodule : hwb_regs

// File: sim/hwb_host_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Host side of the index/data register port
// ****************************************************************
module hwb_host_model
    import hwb_pkg::*;
(
    input  wire logic       i_clk_sys,
    input  wire logic [7:0] i_rd_data,
    output logic      [7:0] o_index,
    output logic            o_wr_en,
    output logic      [7:0] o_wr_data,
    output logic            o_rd_en
);
    // Idle port with both strobes low
    initial begin
        o_index   = 8'h00;
        o_wr_en   = 1'b0;
        o_wr_data = 8'h00;
        o_rd_en   = 1'b0;
    end

    // One write; bank select writes keep the reserved bits 6 and 3 set
    task automatic write_reg(input logic [7:0] idx, input logic [7:0] data);
        o_index   = idx;
        o_wr_data = (idx == HWB_IDX_BANK_SELECT) ? (data | 8'h48) : data;
        o_wr_en   = 1'b1;
        @(posedge i_clk_sys);
        #1;
        o_wr_en   = 1'b0;
        o_index   = ~o_index;   // Released lines do not keep their value
        o_wr_data = ~o_wr_data;
        // Idle edge, so the next request never re-drives a line in this time step
        @(posedge i_clk_sys);
        #1;
    endtask : write_reg

    // One read; data is taken once the registered answer has landed
    task automatic read_reg(input logic [7:0] idx, output logic [7:0] data);
        o_index = idx;
        o_rd_en = 1'b1;
        @(posedge i_clk_sys);
        #1;
        o_rd_en = 1'b0;
        o_index = ~o_index;
        @(posedge i_clk_sys);
        #1;
        data = i_rd_data;
    endtask : read_reg
endmodule : hwb_host_model

// File: sim/hwb_fan_pin_bank_beep_regs_tb.sv
`timescale 1ns/1ps
// ****************************************************************
// Register port, fan pin and beep scenarios
// ****************************************************************
module hwb_fan_pin_bank_beep_regs_tb
    import hwb_pkg::*;
;
    localparam logic [15:0] TB_VID = 16'hA55A;  // Arbitrary identifier value

    logic       clk, rst_b, wr_en, rd_en, beep, cpu_pin, cpu_oe, cpu_tach;
    logic       sys_pin, sys_oe, sys_tach, cpu_ext, sys_ext;
    logic [7:0] index, wr_data, rd_data, oof, d;
    logic [2:0] upper_bank;
    wire        cpu_pin_in;
    wire        sys_pin_in;
    int         errors, samples_checked;

    // Pin level seen by the design: its own drive, else the fan wiring
    assign cpu_pin_in = cpu_oe ? cpu_pin : cpu_ext;
    assign sys_pin_in = sys_oe ? sys_pin : sys_ext;

    // Clock at 100 MHz
    initial clk = 1'b0;
    always #5 clk = ~clk;

    hwb_host_model u_hwb_host_model (.i_clk_sys(clk), .i_rd_data(rd_data), .o_index(index),
        .o_wr_en(wr_en), .o_wr_data(wr_data), .o_rd_en(rd_en));

    hwb_regs #(.VENDOR_ID(TB_VID)) u_hwb_regs (.i_clk_sys(clk), .i_rst_b(rst_b),
        .i_index(index), .i_wr_en(wr_en), .i_wr_data(wr_data), .i_rd_en(rd_en),
        .o_rd_data(rd_data), .i_out_of_limit(oof), .o_beep(beep), .o_upper_bank(upper_bank),
        .i_cpu_fan_pin(cpu_pin_in), .o_cpu_fan_pin(cpu_pin), .o_cpu_fan_pin_oe(cpu_oe),
        .o_cpu_fan_tach(cpu_tach), .i_sys_fan_pin(sys_pin_in), .o_sys_fan_pin(sys_pin),
        .o_sys_fan_pin_oe(sys_oe), .o_sys_fan_tach(sys_tach));

    // Verdict and end of run
    task automatic complete_run();
        if (errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    // Compare one value with its expectation
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Read through the host and compare
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        u_hwb_host_model.read_reg(idx, d);
        check(d, exp);
    endtask : rd

    // Write through the host
    task automatic wr(input logic [7:0] idx, input logic [7:0] data);
        u_hwb_host_model.write_reg(idx, data);
    endtask : wr

    // Let registered outputs follow
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask : settle

    // Fan pin outputs packed as cpu oe, pin, tach, sys oe, pin, tach
    task automatic pins(input logic [7:0] exp);
        check({2'b00, cpu_oe, cpu_pin, cpu_tach, sys_oe, sys_pin, sys_tach}, exp);
    endtask : pins

    // Hang guard
    initial begin
        #20000;
        errors++;
        complete_run();
    end

    // Main sequence
    initial begin
        errors = 0;
        samples_checked = 0;
        rst_b = 1'b0;
        oof = 8'h00;
        cpu_ext = 1'b1;
        sys_ext = 1'b0;
        repeat (2) @(posedge clk);
        #1 rst_b = 1'b1;
        settle();
        pins(8'h08);
        rd(HWB_IDX_FAN_PIN_CTRL, 8'h05);
        rd(HWB_IDX_BANK_SELECT, 8'h80);
        rd(HWB_IDX_VENDOR_ID, TB_VID[15:8]);
        rd(HWB_IDX_BEEP_ONE, 8'h00);
        rd(HWB_IDX_BEEP_TWO, 8'h80);
        wr(HWB_IDX_FAN_PIN_CTRL, 8'hFF);
        settle();
        pins(8'h08);
        rd(HWB_IDX_FAN_PIN_CTRL, 8'h0F);
        cpu_ext = 1'b0;
        sys_ext = 1'b1;
        settle();
        pins(8'h01);
        wr(HWB_IDX_FAN_PIN_CTRL, 8'h0A);
        settle();
        pins(8'h36);
        wr(HWB_IDX_FAN_PIN_CTRL, 8'h00);
        settle();
        pins(8'h24);
        wr(HWB_IDX_FAN_PIN_CTRL, 8'h08);
        settle();
        pins(8'h34);
        wr(HWB_IDX_BANK_SELECT, 8'h00);
        rd(HWB_IDX_BANK_SELECT, 8'h00);
        rd(HWB_IDX_VENDOR_ID, TB_VID[7:0]);
        wr(HWB_IDX_VENDOR_ID, 8'hFF);
        rd(HWB_IDX_VENDOR_ID, TB_VID[7:0]);
        wr(HWB_IDX_BANK_SELECT, 8'h80);
        rd(HWB_IDX_VENDOR_ID, TB_VID[15:8]);
        wr(HWB_IDX_BANK_SELECT, 8'h82);
        settle();
        check({5'h00, upper_bank}, 8'h02);
        wr(HWB_IDX_BEEP_ONE, 8'hFF);
        rd(HWB_IDX_BEEP_ONE, 8'h00);
        wr(HWB_IDX_BANK_SELECT, 8'h80);
        rd(HWB_IDX_BEEP_ONE, 8'h00);
        wr(HWB_IDX_BEEP_ONE, 8'hA5);
        rd(HWB_IDX_BEEP_ONE, 8'hA5);
        wr(8'h20, 8'hFF);
        rd(8'h20, HWB_RD_NONE);
        // Each source alone: blocked by the other enables, passed by its own
        for (int i = 0; i < 8; i++) begin
            wr(HWB_IDX_BEEP_ONE, 8'h01 << i);
            oof = ~(8'h01 << i);
            settle();
            check({7'h00, beep}, 8'h00);
            oof = 8'h01 << i;
            settle();
            check({7'h00, beep}, 8'h01);
        end
        wr(HWB_IDX_BEEP_TWO, 8'h00);
        settle();
        check({7'h00, beep}, 8'h00);
        rd(HWB_IDX_BEEP_TWO, 8'h00);
        wr(HWB_IDX_BEEP_TWO, 8'hFF);
        settle();
        check({7'h00, beep}, 8'h01);
        rd(HWB_IDX_BEEP_TWO, 8'h80);
        // Second reset in mid-run
        rst_b = 1'b0;
        repeat (2) @(posedge clk);
        #1 rst_b = 1'b1;
        settle();
        check({7'h00, beep}, 8'h00);
        rd(HWB_IDX_BEEP_ONE, 8'h00);
        rd(HWB_IDX_FAN_PIN_CTRL, 8'h05);
        rd(HWB_IDX_BANK_SELECT, 8'h80);
        complete_run();
    end
endmodule : hwb_fan_pin_bank_beep_regs_tb
